// file: bench/adc_conversion_host_port_props.sv
/*
 * Pin-level assertions for the converter host port.
 * Assumes one clock domain and a synchronous active-low reset.
 */
module adc_conversion_host_port_props (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_b,
    // bus control pins
    input wire logic i_chip_select_low_active_b,
    input wire logic i_chip_select_high_active,
    input wire logic i_rd_b,
    input wire logic i_wr_b,
    // outputs watched
    input wire logic [11:0] o_data,
    input wire logic o_data_oe,
    input wire logic o_sync_b,
    input wire logic o_ref_external,
    input wire logic o_sleep_control,
    input wire logic [1:0] o_check_select,
    input wire logic o_offset_cal,
    input wire logic o_overrun
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);
    logic rd_act;
    logic wr_act;
    logic [4:0] cfg;

    // strobes as the pins combine them
    assign rd_act = !i_chip_select_low_active_b && i_chip_select_high_active
        && !i_rd_b;
    assign wr_act = !i_chip_select_low_active_b && i_chip_select_high_active
        && !i_wr_b;
    assign cfg = {o_check_select, o_ref_external, o_sleep_control,
        o_offset_cal};

    sequence rd_start;
        $rose(rd_act);
    endsequence
    sequence rd_end;
        $fell(rd_act);
    endsequence
    sequence wr_recent;
        $past(wr_act, 2) || $past(wr_act, 3) || $past(wr_act, 4);
    endsequence

    // reset must be seen even while it is held
    AST_RESET: assert property (disable iff (1'b0)
        !i_rst_b |=> o_sync_b && !o_data_oe && !o_overrun && cfg == 5'h00)
        else $error("outputs not at reset values");
    AST_RD_DRIVE: assert property (rd_start |-> ##[1:4] o_data_oe)
        else $error("read strobe not answered");
    AST_RD_RELEASE: assert property (rd_end |-> ##[1:4] !o_data_oe)
        else $error("bus still driven after read");
    AST_IDLE: assert property ((!rd_act) [*6] |-> !o_data_oe)
        else $error("bus driven without read");
    AST_DATA_HOLD: assert property ($changed(o_data) |-> $rose(o_data_oe))
        else $error("data changed outside a read");
    AST_SYNC_HOLD: assert property ($fell(o_sync_b) |-> $rose(o_data_oe))
        else $error("marker fell outside a read");
    AST_CFG_WRITE: assert property ($changed(cfg) |-> wr_recent)
        else $error("control pins changed without write");
    AST_OVR_CLEAR: assert property ($fell(o_overrun) |-> wr_recent)
        else $error("overrun cleared without write");
    AST_NO_DRIVE_WR: assert property (wr_act [*4] |-> !o_data_oe)
        else $error("bus driven during write");
endmodule : adc_conversion_host_port_props

bind adc_conversion_host_port adc_conversion_host_port_props u_props (
    .i_mclk, .i_rst_b, .i_chip_select_low_active_b,
    .i_chip_select_high_active, .i_rd_b, .i_wr_b, .o_data, .o_data_oe,
    .o_sync_b, .o_ref_external, .o_sleep_control, .o_check_select,
    .o_offset_cal, .o_overrun
);

// file: bench/adc_conversion_host_port_tb_top.sv
/*
 * Self-checking bench for the converter host port.
 * Assumes the bound checker and the host model beside it.
 */
module adc_conversion_host_port_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_mclk;
    logic i_rst_b;
    logic sclk, cs_b, cs_hi, rd_b, wr_b, h_oe, d_oe, sync_b;
    logic ref_ext, sleep, ofs, ovr, prev_oe;
    logic [1:0] chk;
    logic [11:0] h_d, pos, neg, bus, d_out, last_data;
    logic cyc = 1'b0;
    logic [13:0] exp_q[$];
    logic [11:0] fs[3] = '{12'hfff, 12'h800, 12'h000};
    logic [9:0] modes[4] = '{10'h000, 10'h008, 10'h020, 10'h088};
    int error_cnt = 0;
    int n_tests = 0;
    int seed = 16;

    initial begin
        i_mclk = 1'b0;
        forever #25 i_mclk = ~i_mclk;
    end

    // no pull on the data lines: undriven wire toggles
    always @(posedge i_mclk) cyc <= ~cyc;
    assign bus = d_oe ? d_out : (h_oe ? h_d : {12{cyc}} ^ 12'h5a5);

    adc_host_model host (.i_mclk(i_mclk), .o_sclk(sclk), .o_pos(pos),
        .o_neg(neg), .o_cs_b(cs_b), .o_cs_hi(cs_hi), .o_rd_b(rd_b),
        .o_wr_b(wr_b), .o_d(h_d), .o_d_oe(h_oe));

    adc_conversion_host_port dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
        .i_sample_clock_in(sclk), .i_chip_select_low_active_b(cs_b),
        .i_chip_select_high_active(cs_hi), .i_rd_b(rd_b), .i_wr_b(wr_b),
        .i_data(bus), .o_data(d_out), .o_data_oe(d_oe),
        .i_analog_input_positive(pos), .i_analog_input_negative(neg),
        .o_sync_b(sync_b), .o_ref_external(ref_ext),
        .o_sleep_control(sleep), .o_check_select(chk),
        .o_offset_cal(ofs), .o_overrun(ovr));

    task automatic check(input string what, input logic [11:0] seen,
            input logic [11:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // each new drive of the bus is one result: compare oldest note
    always @(negedge i_mclk) begin
        logic [13:0] e;
        if (i_rst_b && d_oe === 1'b1 && prev_oe !== 1'b1) begin
            if (exp_q.size() == 0) begin
                check("unasked drive", 12'h000, 12'h001);
            end else begin
                e = exp_q.pop_front();
                check("read data", d_out, e[11:0]);
                if (e[13]) begin
                    check("marker", {11'h0, sync_b}, {11'h0, e[12]});
                end
            end
        end
        prev_oe = d_oe;
    end

    task automatic read_exp(input logic [13:0] e);
        exp_q.push_back(e);
        last_data = e[11:0];
        host.rd(1'b1);
    endtask : read_exp

    // soft reset flushes old pipeline contents first
    task automatic cfg(input logic [9:0] mode, input logic twos);
        host.wr(2'h1, 10'h001);
        host.wr(2'h0, mode);
        host.wr(2'h1, {2'h0, twos, 7'h00});
    endtask : cfg

    task automatic run(input logic [9:0] mode, input logic twos,
            input int n, input int extra);
        logic [11:0] p, m, r, c;
        logic [13:0] eq[$];
        int d;
        cfg(mode, twos);
        for (int k = 0; k < n + 5 + extra; k++) begin
            r = 12'($random(seed));
            p = (k < 3) ? fs[k] : 12'($random(seed));
            m = (k < 3) ? fs[2 - k] : {r[11:1], p[0]};
            d = (int'(p) - int'(m)) >>> 1;
            case (mode[7:3])
                5'h01: c = m;
                5'h04: c = 12'(d + 2048);
                5'h11: c = k[0] ? m : p;
                default: c = p;
            endcase
            c[11] = c[11] ^ twos;
            eq.push_back({1'b1, ~(mode[7:3] == 5'h11 && !k[0]), c});
            host.conv(p, m);
            if (k == 4) read_exp({2'h0, last_data});
        end
        if (extra > 0) begin
            host.idle(4);
            check("overrun", {11'h0, ovr}, 12'h001);
        end
        for (int k = 0; k < n; k++) read_exp(eq[k]);
        read_exp({2'h0, last_data});
    endtask : run

    task automatic conclude();
        if (error_cnt == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude

    initial begin
        i_rst_b = 1'b0;
        repeat (10) @(posedge i_mclk);
        i_rst_b <= 1'b1;
        repeat (3) @(posedge i_mclk);
        check("cfg pins", {7'h0, chk, sleep, ref_ext, ofs}, 12'h000);
        // echo mode shows both registers without popping results
        host.wr(2'h1, 10'h3c0);
        check("offset", {11'h0, ofs}, 12'h001);
        read_exp({2'h0, 2'h0, 10'h020});
        read_exp({2'h0, 2'h1, 10'h3c0});
        host.wr(2'h0, 10'h155);
        check("cfg pins", {8'h0, chk, sleep, ref_ext}, 12'h007);
        host.wr(2'h2, 10'h3ff);
        host.wr(2'h3, 10'h3ff);
        host.rd(1'b0);
        read_exp({2'h0, 2'h0, 10'h155});
        read_exp({2'h0, 2'h1, 10'h3c0});
        for (int i = 0; i < 8; i++) run(modes[i / 2], i[0], 6, 0);
        run(10'h000, 1'b0, 32, 3);
        host.wr(2'h1, 10'h001);
        check("overrun", {11'h0, ovr}, 12'h000);
        run(10'h004, 1'b0, 0, 0);
        run(10'h010, 1'b0, 0, 0);
        for (int i = 0; i < 20 && exp_q.size() > 0; i++) @(posedge i_mclk);
        if (exp_q.size() > 0) check("pending", 12'h000, 12'h001);
        conclude();
    end
endmodule : adc_conversion_host_port_tb_top

// file: bench/adc_host_model.sv
/*
 * Host side model: conversion clock, analog codes and bus cycles.
 * Assumes each task is entered just after a rising i_mclk edge.
 */
module adc_host_model (
    // clock
    input wire logic i_mclk,
    // conversion clock and analog codes
    output logic o_sclk,
    output logic [11:0] o_pos,
    output logic [11:0] o_neg,
    // bus control and write data
    output logic o_cs_b,
    output logic o_cs_hi,
    output logic o_rd_b,
    output logic o_wr_b,
    output logic [11:0] o_d,
    output logic o_d_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle bus, clock parked low
    initial begin
        {o_sclk, o_cs_b, o_cs_hi, o_rd_b, o_wr_b, o_d_oe} = 6'h1e;
        {o_pos, o_neg, o_d} = 36'h0;
    end

    task automatic idle(input int n);
        repeat (n) @(posedge i_mclk);
    endtask : idle

    // even phases; codes move only mid high phase, far from the fall
    task automatic conv(input logic [11:0] p, input logic [11:0] n);
        o_sclk <= 1'b1;
        idle(2);
        o_pos <= p;
        o_neg <= n;
        idle(2);
        o_sclk <= 1'b0;
        idle(4);
    endtask : conv

    // one strobe per call; hi low gives a deselected cycle
    task automatic rd(input logic hi);
        {o_cs_b, o_cs_hi, o_rd_b} <= {1'b0, hi, 1'b0};
        idle(4);
        {o_cs_b, o_cs_hi, o_rd_b} <= 3'b101;
        idle(5);
    endtask : rd

    // data held past the strobe since capture lags the pins
    task automatic wr(input logic [1:0] a, input logic [9:0] v);
        o_d <= {a, v};
        o_d_oe <= 1'b1;
        {o_cs_b, o_cs_hi, o_wr_b} <= 3'b010;
        idle(4);
        {o_cs_b, o_cs_hi, o_wr_b} <= 3'b101;
        idle(4);
        o_d_oe <= 1'b0;
        idle(1);
    endtask : wr
endmodule : adc_host_model

// file: core/adc_conversion_host_port.sv
/*
 * Digital side of a two-input pipelined 12-bit sampling converter:
 * conversion timing, channel sequencing, code format, result buffer,
 * parallel bus read and control register write.
 * Assumes every pin arrives asynchronously to i_mclk, that the analog
 * core presents each input as a 12-bit offset binary code, and that
 * the conversion clock is at most a fraction of i_mclk.
 */
// Notes on behaviour
// RULE_01: each conversion clock fall starts a conversion
// RULE_02: result readable five conversion clocks later
// RULE_03: host supplies free running 50 percent clock
// RULE_04: per-channel rate is aggregate over channel count
// RULE_05: one result per fall, one read collects it
// RULE_06: marker low while bus holds channel one
// RULE_07: single input keeps marker inactive
// RULE_08: read strobe combines both selects and read
// RULE_09: format bit picks binary or twos complement
// RULE_10: single-ended binary: FFF top, 800 mid, 000
// RULE_11: single-ended twos: 7FF top, 000 mid, 800
// RULE_12: differential binary: FFF, 800, 000
// RULE_13: differential twos: 7FF, 000, 800
// RULE_14: two ten-bit control registers set mode
// RULE_15: host writes value low, address top lines
// RULE_16: address 00 mode, 01 aux, others reserved
// RULE_17: mode register field layout, bit nine down
// RULE_18: aux register field layout, echo to reset
// RULE_19: external reference only when selected
// RULE_20: reference select and sleep bit meaning
// RULE_21: bus stays usable during sleep
// RULE_22: channel codes 00000 00001 00100 10001 only
// RULE_23: mode register resets with bit five set
// RULE_24: two-channel results alternate, first then second
// RULE_25: host reads once per clock, not across fall
// RULE_26: host writes both registers before use
`include "adc_port_cfg.svh"

module adc_conversion_host_port (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_b,
    // conversion clock pin
    input wire logic i_sample_clock_in,
    // bus control pins
    input wire logic i_chip_select_low_active_b,
    input wire logic i_chip_select_high_active,
    input wire logic i_rd_b,
    input wire logic i_wr_b,
    // two-way data bus
    input wire logic [`CODE_W-1:0] i_data,
    output logic [`CODE_W-1:0] o_data,
    output logic o_data_oe,
    // analog core codes
    input wire logic [`CODE_W-1:0] i_analog_input_positive,
    input wire logic [`CODE_W-1:0] i_analog_input_negative,
    // status and analog control
    output logic o_sync_b,
    output logic o_ref_external,
    output logic o_sleep_control,
    output logic [1:0] o_check_select,
    output logic o_offset_cal,
    output logic o_overrun
);
    typedef struct packed {
        logic [`PIN_W-1:0] pin_s1;
        logic [`PIN_W-1:0] pin_s2;
        logic [`CODE_W-1:0] bus_s1;
        logic [`CODE_W-1:0] bus_s2;
        logic [`CODE_W-1:0] pos_s1;
        logic [`CODE_W-1:0] pos_s2;
        logic [`CODE_W-1:0] neg_s1;
        logic [`CODE_W-1:0] neg_s2;
        logic conv_prev;
        logic rd_prev;
        logic wr_prev;
        logic [`CODE_W-1:0] wr_word;
        logic [`REG_W-1:0] mode_cfg;
        logic [`REG_W-1:0] aux_cfg;
        logic scan_second;
        logic echo_second;
        logic [`CODE_W-1:0] data_out;
        logic data_oe;
        logic sync_b;
        logic overrun;
        logic flush;
    } port_state_t;

    port_state_t st;
    port_state_t next_st;

    // buffer and pipeline wiring
    logic pipe_valid;
    logic pipe_first;
    logic [`CODE_W-1:0] pipe_code;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [`CODE_W:0] fifo_out_data;
    logic advance;
    logic start;
    logic first_ch;
    logic pop;
    logic [`CODE_W-1:0] new_code;

    adc_port_pkg::chan_mode_t chan_mode;

    // outputs are fields of the state register
    assign o_data = st.data_out;
    assign o_data_oe = st.data_oe;
    assign o_sync_b = st.sync_b;
    assign o_ref_external = st.mode_cfg[`MODE_REF_BIT]; // RULE_19
    assign o_sleep_control = st.mode_cfg[`MODE_SLEEP_BIT]; // RULE_20
    assign o_check_select = st.mode_cfg[`MODE_CHECK_MSB:`MODE_CHECK_LSB];
    assign o_offset_cal = st.aux_cfg[`AUX_OFFSET_BIT];
    assign o_overrun = st.overrun;

    // channel setting from bits 7..3, reserved codes convert nothing
    assign chan_mode = adc_port_pkg::decode_chan(
        st.mode_cfg[`MODE_CHAN_MSB:`MODE_CHAN_LSB]); // RULE_22

    sample_pipe u_pipe (
        .i_mclk(i_mclk),
        .i_rst_b(i_rst_b),
        .i_flush(st.flush),
        .i_advance(advance),
        .i_valid(start),
        .i_first_ch(first_ch),
        .i_code(new_code),
        .o_valid(pipe_valid),
        .o_first_ch(pipe_first),
        .o_code(pipe_code)
    );

    // full buffer holds the pipe; a conversion that cannot enter is lost
    result_fifo #(
        .WIDTH(`CODE_W + 1),
        .DEPTH(`FIFO_DEPTH)
    ) u_fifo (
        .i_mclk(i_mclk),
        .i_rst_b(i_rst_b),
        .i_flush(st.flush),
        .i_in_valid(pipe_valid && advance),
        .o_in_ready(fifo_in_ready),
        .i_in_data({pipe_first, pipe_code}),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(pop),
        .o_out_data(fifo_out_data)
    );

    // main next-state logic
    always_comb begin
        logic conv_fall;
        logic rd_act;
        logic wr_act;
        logic wr_end;
        logic rd_start;
        logic sleep;
        logic [`CODE_W:0] diff;
        logic [`CODE_W-1:0] raw;
        logic [1:0] ra;
        conv_fall = 1'b0;
        rd_act = 1'b0;
        wr_act = 1'b0;
        wr_end = 1'b0;
        rd_start = 1'b0;
        sleep = st.mode_cfg[`MODE_SLEEP_BIT];
        diff = '0;
        raw = '0;
        ra = '0;
        next_st = st;
        next_st.flush = 1'b0;

        // two-stage synchronisers for every pin
        next_st.pin_s1 = {i_wr_b, i_rd_b, i_chip_select_high_active,
                          i_chip_select_low_active_b, i_sample_clock_in};
        next_st.pin_s2 = st.pin_s1;
        next_st.bus_s1 = i_data;
        next_st.bus_s2 = st.bus_s1;
        next_st.pos_s1 = i_analog_input_positive;
        next_st.pos_s2 = st.pos_s1;
        next_st.neg_s1 = i_analog_input_negative;
        next_st.neg_s2 = st.neg_s1;

        // edge detection on synchronised levels only
        next_st.conv_prev = st.pin_s2[`PIN_CONV];
        conv_fall = st.conv_prev && !st.pin_s2[`PIN_CONV]; // RULE_01 RULE_03
        rd_act = !st.pin_s2[`PIN_CS_B] && st.pin_s2[`PIN_CS_HI]
                 && !st.pin_s2[`PIN_RD_B]; // RULE_08
        wr_act = !st.pin_s2[`PIN_CS_B] && st.pin_s2[`PIN_CS_HI]
                 && !st.pin_s2[`PIN_WR_B]; // RULE_08
        next_st.rd_prev = rd_act;
        next_st.wr_prev = wr_act;
        rd_start = rd_act && !st.rd_prev;
        wr_end = st.wr_prev && !wr_act;

        // sleep halts conversions only, the bus keeps working
        start = conv_fall && !sleep
                && (chan_mode != adc_port_pkg::CH_RSVD); // RULE_21
        advance = conv_fall && (!pipe_valid || fifo_in_ready); // RULE_02

        // autoscan alternates inputs, positive one first
        first_ch = 1'b1;
        if (chan_mode == adc_port_pkg::CH_SCAN) begin
            first_ch = !st.scan_second; // RULE_24
            if (start && advance) begin
                next_st.scan_second = !st.scan_second; // RULE_04
            end
        end else begin
            next_st.scan_second = 1'b0;
        end

        // difference halved about mid code keeps full span in 12 bits
        diff = {1'b0, st.pos_s2} - {1'b0, st.neg_s2};
        unique case (chan_mode)
            adc_port_pkg::CH_NEG: raw = st.neg_s2; // RULE_10
            adc_port_pkg::CH_DIFF: raw = diff[`CODE_W:1]
                                         + `MID_CODE; // RULE_12
            adc_port_pkg::CH_SCAN: raw = st.scan_second ? st.neg_s2
                                                        : st.pos_s2;
            default: raw = st.pos_s2; // RULE_10
        endcase
        new_code = adc_port_pkg::format_code(raw,
            st.aux_cfg[`AUX_FORMAT_BIT]); // RULE_09 RULE_11 RULE_13

        // a started conversion the pipe could not take is counted lost
        if (start && !advance) begin
            next_st.overrun = 1'b1;
        end

        // write: hold the word while strobed, commit at strobe end
        if (wr_act) begin
            next_st.wr_word = st.bus_s2; // RULE_15
        end
        ra = st.wr_word[`RA_MSB:`RA_LSB];
        if (wr_end) begin
            if (ra == `ADDR_MODE_REG) begin // RULE_16
                next_st.mode_cfg = st.wr_word[`REG_W-1:0]; // RULE_14 RULE_17
            end else if (ra == `ADDR_AUX_REG) begin // RULE_16
                next_st.aux_cfg = st.wr_word[`REG_W-1:0]; // RULE_18
                if (st.wr_word[`AUX_RESET_BIT]) begin
                    // soft reset restores defaults and drops results
                    next_st.mode_cfg = `MODE_REG_RESET; // RULE_23
                    next_st.aux_cfg = `AUX_REG_RESET;
                    next_st.flush = 1'b1;
                    next_st.overrun = 1'b0;
                    next_st.scan_second = 1'b0;
                end
            end
        end

        // read: echo mode returns the registers, else pops a result
        pop = 1'b0;
        next_st.data_oe = rd_act;
        if (rd_start) begin
            if (st.aux_cfg[`AUX_ECHO_BIT]) begin
                next_st.echo_second = !st.echo_second;
                next_st.data_out = st.echo_second
                    ? {`ADDR_AUX_REG, st.aux_cfg}
                    : {`ADDR_MODE_REG, st.mode_cfg};
            end else if (fifo_out_valid) begin
                pop = 1'b1; // RULE_05 RULE_25
                next_st.data_out = fifo_out_data[`CODE_W-1:0];
                next_st.sync_b = !fifo_out_data[`CODE_W]; // RULE_06
            end
        end
        if (!st.aux_cfg[`AUX_ECHO_BIT]) begin
            next_st.echo_second = 1'b0;
        end
        if (chan_mode != adc_port_pkg::CH_SCAN) begin
            next_st.sync_b = 1'b1; // RULE_07
        end
    end

    // state register; reset gives documented register defaults
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            st <= '0;
            st.mode_cfg <= `MODE_REG_RESET; // RULE_23 RULE_26
            st.aux_cfg <= `AUX_REG_RESET;
            st.sync_b <= 1'b1;
            st.conv_prev <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

endmodule : adc_conversion_host_port

// file: core/adc_port_cfg.svh
/*
 * Constants of the converter host port: widths, bit positions, reset
 * values, channel codes and pipeline figures.
 * Assumes it is included by its bare name by every file that needs it.
 */
`ifndef ADC_PORT_CFG_SVH
`define ADC_PORT_CFG_SVH

// widths and depths
`define CODE_W 12
`define REG_W 10
`define PIPE_LATENCY 5
`define FIFO_DEPTH 32

// register addressing on the two upper data lines
`define RA_LSB 10
`define RA_MSB 11
`define ADDR_MODE_REG 2'h0
`define ADDR_AUX_REG 2'h1

// reset values of the two control registers
`define MODE_REG_RESET 10'h020
`define AUX_REG_RESET 10'h000

// mode_config_register fields
`define MODE_REF_BIT 0
`define MODE_SLEEP_BIT 2
`define MODE_CHAN_LSB 3
`define MODE_CHAN_MSB 7
`define MODE_CHECK_LSB 8
`define MODE_CHECK_MSB 9

// aux_config_register fields
`define AUX_RESET_BIT 0
`define AUX_RW_BIT 6
`define AUX_FORMAT_BIT 7
`define AUX_OFFSET_BIT 8
`define AUX_ECHO_BIT 9

// channel configuration codes, bits 7 to 3
`define CHAN_POS 5'h00
`define CHAN_NEG 5'h01
`define CHAN_DIFF 5'h04
`define CHAN_SCAN 5'h11

// code arithmetic
`define MID_CODE 12'h800
`define SIGN_BIT 11

// positions of the conversion clock and bus control pins in the synchroniser vector
`define PIN_W 5
`define PIN_CONV 0
`define PIN_CS_B 1
`define PIN_CS_HI 2
`define PIN_RD_B 3
`define PIN_WR_B 4

`endif

// file: core/adc_port_pkg.sv
/*
 * Types and shared helpers of the converter host port.
 * Assumes adc_port_cfg.svh is available on the include path.
 */
`include "adc_port_cfg.svh"

package adc_port_pkg;

    typedef enum logic [2:0] {
        CH_POS,
        CH_NEG,
        CH_DIFF,
        CH_SCAN,
        CH_RSVD
    } chan_mode_t;

    // channel field decode; every unlisted code is reserved
    function automatic chan_mode_t decode_chan(input logic [4:0] f);
        chan_mode_t m;
        case (f)
            `CHAN_POS: m = CH_POS;
            `CHAN_NEG: m = CH_NEG;
            `CHAN_DIFF: m = CH_DIFF;
            `CHAN_SCAN: m = CH_SCAN;
            default: m = CH_RSVD;
        endcase
        return m;
    endfunction : decode_chan

    // binary to twos complement is a flip of the top bit
    function automatic logic [`CODE_W-1:0] format_code(
        input logic [`CODE_W-1:0] c,
        input logic twos
    );
        logic [`CODE_W-1:0] r;
        r = c;
        r[`SIGN_BIT] = c[`SIGN_BIT] ^ twos;
        return r;
    endfunction : format_code

endpackage : adc_port_pkg

// file: core/result_fifo.sv
/*
 * Result FIFO with valid/ready on both sides and a flush.
 * Assumes one clock, synchronous active-low reset.
 */
`include "adc_port_cfg.svh"

module result_fifo #(
    parameter int WIDTH = `CODE_W + 1,
    parameter int DEPTH = `FIFO_DEPTH
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_flush,
    // fill side
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    // drain side
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW:0] wr_ptr;
        logic [AW:0] rd_ptr;
    } fifo_state_t;

    fifo_state_t st;
    fifo_state_t next_st;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    // extra pointer bit tells full from empty
    assign o_out_valid = st.wr_ptr != st.rd_ptr;
    assign o_in_ready = !((st.wr_ptr[AW] != st.rd_ptr[AW])
                          && (st.wr_ptr[AW-1:0] == st.rd_ptr[AW-1:0]));
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;
    assign o_out_data = mem[st.rd_ptr[AW-1:0]];

    // pointer update; flush empties without touching the array
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.wr_ptr = st.wr_ptr + 1'b1;
        end
        if (pop) begin
            next_st.rd_ptr = st.rd_ptr + 1'b1;
        end
        if (i_flush) begin
            next_st.rd_ptr = next_st.wr_ptr;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // storage needs no reset, entries are read only once written
    always_ff @(posedge i_mclk) begin
        if (push) begin
            mem[st.wr_ptr[AW-1:0]] <= i_in_data;
        end
    end

endmodule : result_fifo

// file: core/sample_pipe.sv
/*
 * Conversion pipeline: results step one stage per conversion edge.
 * Assumes i_advance is a one-cycle pulse per conversion clock fall.
 */
`include "adc_port_cfg.svh"

module sample_pipe (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_flush,
    // stage control and new sample
    input wire logic i_advance,
    input wire logic i_valid,
    input wire logic i_first_ch,
    input wire logic [`CODE_W-1:0] i_code,
    // last stage, leaves on the next advance
    output logic o_valid,
    output logic o_first_ch,
    output logic [`CODE_W-1:0] o_code
);
    typedef struct packed {
        logic [`PIPE_LATENCY-1:0] valid;
        logic [`PIPE_LATENCY-1:0] first_ch;
        logic [`PIPE_LATENCY-1:0][`CODE_W-1:0] code;
    } pipe_state_t;

    pipe_state_t st;
    pipe_state_t next_st;

    assign o_valid = st.valid[`PIPE_LATENCY-1];
    assign o_first_ch = st.first_ch[`PIPE_LATENCY-1];
    assign o_code = st.code[`PIPE_LATENCY-1];

    // shift on each advance; the sample leaves on the fifth
    always_comb begin
        next_st = st;
        if (i_advance) begin
            next_st.valid = {st.valid[`PIPE_LATENCY-2:0], i_valid};
            next_st.first_ch = {st.first_ch[`PIPE_LATENCY-2:0], i_first_ch};
            next_st.code = {st.code[`PIPE_LATENCY-2:0], i_code};
        end
        if (i_flush) begin
            next_st.valid = '0;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

endmodule : sample_pipe
